// ### src/uim_pkg.sv
package uim_pkg;
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  // Register byte offsets
  localparam logic [7:0] OFF_ENABLE_MASK = 8'h00;
  localparam logic [7:0] OFF_RAW_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASKED_STATUS = 8'h08;
  // Field layout: sources sit contiguously from bit 4 upward
  localparam int SRC_LSB = 4;
  localparam int NUM_SRC = 5;
  localparam int RX_IRQ_BIT = 4;
  localparam int TX_IRQ_BIT = 5;
  localparam int RX_TIMEOUT_BIT = 6;
  localparam int FRAMING_ERR_BIT = 7;
  localparam int PARITY_ERR_BIT = 8;
  localparam int RSVD_LO_MSB = 3;
  // Reset values
  localparam logic ENABLE_RESET = 1'b0;
  localparam logic RAW_RESET = 1'b0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [3:0] RSVD_LO_VALUE = 4'h0;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } uim_avs_req_t;

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
  } uim_avs_rsp_t;
endpackage

// ### src/uim_avs_slave.sv
`timescale 1ns/10ps
module uim_avs_slave (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Bus request and read value of the addressed register
  input uim_pkg::uim_avs_req_t i_req,
  input wire logic [31:0] i_rdata_mux,
  // Bus answer
  output uim_pkg::uim_avs_rsp_t o_rsp,
  output logic o_wr_acc
);
  logic wait_r;
  logic wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // Every access waits exactly one cycle; keeps decode off the request path
  always_comb begin
    wait_nxt = !((i_req.read || i_req.write) && wait_r);
    rdata_nxt = rdata_r;
    if (i_req.read && wait_r) begin
      rdata_nxt = i_rdata_mux;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wait_r <= 1'b1;
      rdata_r <= uim_pkg::RDATA_RESET;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_wr_acc = i_req.write && !wait_r;
  assign o_rsp.waitreq = wait_r;
  assign o_rsp.rdata = rdata_r;
endmodule // uim_avs_slave

// ### src/uim_src_cell.sv
`timescale 1ns/10ps
module uim_src_cell (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Source event and software strobes
  input wire logic i_event,
  input wire logic i_en_wr,
  input wire logic i_en_wdata,
  input wire logic i_raw_clr,
  // State
  output logic o_en,
  output logic o_raw,
  output logic o_en_nxt,
  output logic o_raw_nxt
);
  logic en_r;
  logic en_nxt;
  logic raw_r;
  logic raw_nxt;

  always_comb begin
    en_nxt = i_en_wr ? i_en_wdata : en_r;
    // Set wins over a clear in the same cycle, so no event is lost
    raw_nxt = i_event || (raw_r && !i_raw_clr);
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      en_r <= uim_pkg::ENABLE_RESET;
      raw_r <= uim_pkg::RAW_RESET;
    end else begin
      en_r <= en_nxt;
      raw_r <= raw_nxt;
    end
  end

  assign o_en = en_r;
  assign o_raw = raw_r;
  assign o_en_nxt = en_nxt;
  assign o_raw_nxt = raw_nxt;
endmodule // uim_src_cell

// ### src/uim_top.sv
// What this block does
// - The parity-error enable at bit 8 is read/write, reads back its value, and a 1 forwards it.
// - The framing-error enable at bit 7 is read/write, resets to 0, and a 1 forwards it.
// - The receive time-out enable at bit 6 is read/write, resets to 0, and a 1 forwards it.
// - The transmit enable at bit 5 is read/write, resets to 0, and a 1 forwards it.
// - The receive enable at bit 4 is read/write, resets to 0, and a 1 forwards it.
// - Bits 3 to 0 are read-only zero and software preserves them on read-modify-write.
// - Each masked state is the raw state gated by its enable, never active when disabled.
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module uim_top #(
  parameter int N_SRC = uim_pkg::NUM_SRC
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESETN,
  // Avalon-MM slave
  input wire logic [7:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // Raw events from the UART core, bit 0 = receive
  input wire logic [N_SRC-1:0] I_RAW_EVENT,
  // Interrupt side
  output logic [N_SRC-1:0] O_MASKED_STATE,
  output logic O_IRQ
);
  localparam int LSB = uim_pkg::SRC_LSB;
  localparam int TOP_PAD = 32 - N_SRC - LSB;

  if (N_SRC < 1 || TOP_PAD < 0) begin : g_bad_param
    $error("uim_top: N_SRC does not fit the register word");
  end

  uim_pkg::uim_avs_req_t req;
  uim_pkg::uim_avs_rsp_t rsp;
  logic wr_acc;
  logic [31:0] rdata_mux;
  logic sel_mask;
  logic sel_raw;
  logic sel_masked;
  logic mask_wr;
  logic raw_wr;
  logic [N_SRC-1:0] en_w;
  logic [N_SRC-1:0] raw_w;
  logic [N_SRC-1:0] en_nxt_w;
  logic [N_SRC-1:0] raw_nxt_w;
  logic [N_SRC-1:0] masked_r;
  logic [N_SRC-1:0] masked_nxt;
  logic irq_r;
  logic irq_nxt;

  assign req.read = I_AVS_READ;
  assign req.write = I_AVS_WRITE;
  assign req.addr = I_AVS_ADDRESS;
  assign req.wdata = I_AVS_WRITEDATA;
  assign req.be = I_AVS_BYTEENABLE;

  // Word decode; the two low address bits are ignored
  assign sel_mask = req.addr[7:2] == uim_pkg::OFF_ENABLE_MASK[7:2];
  assign sel_raw = req.addr[7:2] == uim_pkg::OFF_RAW_STATUS[7:2];
  assign sel_masked = req.addr[7:2] == uim_pkg::OFF_MASKED_STATUS[7:2];
  assign mask_wr = wr_acc && sel_mask;
  assign raw_wr = wr_acc && sel_raw;

  always_comb begin
    rdata_mux = 32'h0000_0000;
    if (sel_mask) begin
      rdata_mux = {{TOP_PAD{1'b0}}, en_w, uim_pkg::RSVD_LO_VALUE};
    end else if (sel_raw) begin
      rdata_mux = {{TOP_PAD{1'b0}}, raw_w, uim_pkg::RSVD_LO_VALUE};
    end else if (sel_masked) begin
      rdata_mux = {{TOP_PAD{1'b0}}, raw_w & en_w, uim_pkg::RSVD_LO_VALUE};
    end
  end

  uim_avs_slave u_avs (
    .i_clk(I_CLK),
    .i_resetn(I_RESETN),
    .i_req(req),
    .i_rdata_mux(rdata_mux),
    .o_rsp(rsp),
    .o_wr_acc(wr_acc)
  );

  for (genvar i = 0; i < N_SRC; i++) begin : g_src
    localparam int POS = LSB + i;
    uim_src_cell u_cell (
      .i_clk(I_CLK),
      .i_resetn(I_RESETN),
      .i_event(I_RAW_EVENT[i]),
      .i_en_wr(mask_wr && req.be[POS/8]),
      .i_en_wdata(req.wdata[POS]),
      .i_raw_clr(raw_wr && req.be[POS/8] && req.wdata[POS]),
      .o_en(en_w[i]),
      .o_raw(raw_w[i]),
      .o_en_nxt(en_nxt_w[i]),
      .o_raw_nxt(raw_nxt_w[i])
    );
  end

  // Outputs track the next state so they line up with the registers
  always_comb begin
    masked_nxt = raw_nxt_w & en_nxt_w;
    irq_nxt = |masked_nxt;
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      masked_r <= '0;
      irq_r <= 1'b0;
    end else begin
      masked_r <= masked_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign O_MASKED_STATE = masked_r;
  assign O_IRQ = irq_r;
  assign O_AVS_READDATA = rsp.rdata;
  assign O_AVS_WAITREQUEST = rsp.waitreq;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);

  logic req_any;
  assign req_any = I_AVS_READ || I_AVS_WRITE;

  a_wait_one_cycle: assert property (req_any && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("waitrequest did not drop one cycle after a request");

  a_wait_short_low: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("waitrequest stayed low for more than one cycle");

  a_parity_en_wr: assert property (
    mask_wr && I_AVS_BYTEENABLE[1] |=> en_w[4] == $past(I_AVS_WRITEDATA[8]))
    else $error("parity enable did not take written value");

  a_low_en_wr: assert property (
    mask_wr && I_AVS_BYTEENABLE[0] |=> en_w[3:0] == $past(I_AVS_WRITEDATA[7:4]))
    else $error("low enable bits did not take written value");

  a_en_hold_idle: assert property (
    !mask_wr |=> en_w == $past(en_w))
    else $error("enable bits changed without a mask write");

  a_mask_readback: assert property (
    I_AVS_READ && O_AVS_WAITREQUEST && sel_mask |=> O_AVS_READDATA[8:4] == $past(en_w))
    else $error("mask read did not return stored enables");

  a_rsvd_zero: assert property (
    I_AVS_READ && !O_AVS_WAITREQUEST |-> O_AVS_READDATA[3:0] == 4'h0)
    else $error("reserved low bits read nonzero");

  a_gate_masked: assert property (
    O_MASKED_STATE == (raw_w & en_w))
    else $error("masked state differs from raw and enable");

  a_irq_or: assert property (
    O_IRQ == |(raw_w & en_w))
    else $error("interrupt is not the OR of masked states");

  a_event_sets: assert property (
    I_RAW_EVENT[0] |=> raw_w[0] && (O_MASKED_STATE[0] == en_w[0]))
    else $error("receive event not captured");

  a_reset_clears: assert property (@(posedge I_CLK) disable iff (1'b0)
    !I_RESETN |=> en_w == '0 && !O_IRQ && O_AVS_WAITREQUEST)
    else $error("reset did not clear enables");

  a_reset_raw: assert property (@(posedge I_CLK) disable iff (1'b0)
    !I_RESETN |=> raw_w == '0 && O_MASKED_STATE == '0 && O_AVS_READDATA == '0)
    else $error("reset did not clear raw state or read data");

  a_raw_readback: assert property (
    I_AVS_READ && O_AVS_WAITREQUEST && sel_raw
    |=> O_AVS_READDATA[LSB +: N_SRC] == $past(raw_w))
    else $error("raw status read did not return stored bits");

  a_masked_readback: assert property (
    I_AVS_READ && O_AVS_WAITREQUEST && sel_masked
    |=> O_AVS_READDATA[LSB +: N_SRC] == $past(raw_w & en_w))
    else $error("masked status read did not return gated bits");

  a_upper_zero: assert property (
    I_AVS_READ && !O_AVS_WAITREQUEST |-> (O_AVS_READDATA >> (LSB + N_SRC)) == '0)
    else $error("bits above the enables read nonzero");

  a_unmapped_zero: assert property (
    I_AVS_READ && O_AVS_WAITREQUEST && !sel_mask && !sel_raw && !sel_masked
    |=> O_AVS_READDATA == '0)
    else $error("unmapped read returned nonzero");

  a_rdata_hold: assert property (
    !(I_AVS_READ && O_AVS_WAITREQUEST) |=> $stable(O_AVS_READDATA))
    else $error("read data changed without a new read");

  // Enable vector positions of the named sources
  localparam int IDX_RX = uim_pkg::RX_IRQ_BIT - LSB;
  localparam int IDX_TX = uim_pkg::TX_IRQ_BIT - LSB;
  localparam int IDX_RT = uim_pkg::RX_TIMEOUT_BIT - LSB;
  localparam int IDX_FE = uim_pkg::FRAMING_ERR_BIT - LSB;
  localparam int IDX_PE = uim_pkg::PARITY_ERR_BIT - LSB;

  // Named sources only exist at the documented source count
  if (N_SRC == uim_pkg::NUM_SRC) begin : g_named_chk
    a_parity_fwd: assert property (
      en_w[IDX_PE] && raw_w[IDX_PE] |-> O_MASKED_STATE[IDX_PE] && O_IRQ)
      else $error("enabled parity error not forwarded");

    a_framing_en_wr: assert property (
      mask_wr && I_AVS_BYTEENABLE[uim_pkg::FRAMING_ERR_BIT / 8]
      |=> en_w[IDX_FE] == $past(I_AVS_WRITEDATA[uim_pkg::FRAMING_ERR_BIT]))
      else $error("framing enable did not take written value");

    a_framing_fwd: assert property (
      en_w[IDX_FE] && raw_w[IDX_FE] |-> O_MASKED_STATE[IDX_FE] && O_IRQ)
      else $error("enabled framing error not forwarded");

    a_rxto_en_wr: assert property (
      mask_wr && I_AVS_BYTEENABLE[uim_pkg::RX_TIMEOUT_BIT / 8]
      |=> en_w[IDX_RT] == $past(I_AVS_WRITEDATA[uim_pkg::RX_TIMEOUT_BIT]))
      else $error("time-out enable did not take written value");

    a_rxto_fwd: assert property (
      en_w[IDX_RT] && raw_w[IDX_RT] |-> O_MASKED_STATE[IDX_RT] && O_IRQ)
      else $error("enabled receive time-out not forwarded");

    a_tx_en_wr: assert property (
      mask_wr && I_AVS_BYTEENABLE[uim_pkg::TX_IRQ_BIT / 8]
      |=> en_w[IDX_TX] == $past(I_AVS_WRITEDATA[uim_pkg::TX_IRQ_BIT]))
      else $error("transmit enable did not take written value");

    a_tx_fwd: assert property (
      en_w[IDX_TX] && raw_w[IDX_TX] |-> O_MASKED_STATE[IDX_TX] && O_IRQ)
      else $error("enabled transmit interrupt not forwarded");

    a_rx_en_wr: assert property (
      mask_wr && I_AVS_BYTEENABLE[uim_pkg::RX_IRQ_BIT / 8]
      |=> en_w[IDX_RX] == $past(I_AVS_WRITEDATA[uim_pkg::RX_IRQ_BIT]))
      else $error("receive enable did not take written value");

    a_rx_fwd: assert property (
      en_w[IDX_RX] && raw_w[IDX_RX] |-> O_MASKED_STATE[IDX_RX] && O_IRQ)
      else $error("enabled receive interrupt not forwarded");
  end

  // Per-source gating, sticky raw state and lane gating
  for (genvar k = 0; k < N_SRC; k++) begin : g_src_chk
    localparam int P = LSB + k;

    a_masked_off: assert property (
      !en_w[k] |-> !O_MASKED_STATE[k])
      else $error("disabled source shows as masked-active");

    a_raw_clear: assert property (
      raw_wr && I_AVS_BYTEENABLE[P/8] && I_AVS_WRITEDATA[P] && !I_RAW_EVENT[k]
      |=> !raw_w[k])
      else $error("raw bit not cleared by a write of one");

    a_raw_set_wins: assert property (
      I_RAW_EVENT[k] |=> raw_w[k])
      else $error("raw bit lost an event");

    a_raw_sticky: assert property (
      raw_w[k] && !raw_wr |=> raw_w[k])
      else $error("raw bit dropped without a clear");

    a_en_lane_hold: assert property (
      mask_wr && !I_AVS_BYTEENABLE[P/8] |=> en_w[k] == $past(en_w[k]))
      else $error("enable changed on a disabled byte lane");
  end

  c_irq_raised: cover property (mask_wr ##[1:20] $rose(O_IRQ));
  c_mask_read: cover property (I_AVS_READ && sel_mask && !O_AVS_WAITREQUEST);
  c_clear_drop: cover property (raw_wr ##1 $fell(O_IRQ));
  c_lane_partial: cover property (mask_wr && I_AVS_BYTEENABLE[1:0] == 2'h1);
  c_unmapped_read: cover property (
    I_AVS_READ && !O_AVS_WAITREQUEST && !sel_mask && !sel_raw && !sel_masked);
endmodule // uim_top

// ### tb/tb.sv
`timescale 1ns/10ps
module tb;
  logic I_CLK = 1'b0;
  logic I_RESETN = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hf;
  logic [3:0] bl = 4'hf;
  logic [4:0] lm;
  logic [4:0] ev = 5'h00;
  logic [31:0] rdata;
  logic wreq;
  logic [4:0] msk;
  logic irq;
  logic [31:0] q;
  logic [31:0] r;
  logic [31:0] s;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 14819;
  int en = 0;
  int raw = 0;

  always #5 I_CLK = ~I_CLK;

  uim_top i_dut (
    .I_CLK(I_CLK),
    .I_RESETN(I_RESETN),
    .I_AVS_ADDRESS(adr),
    .I_AVS_READ(rd),
    .I_AVS_WRITE(wr),
    .I_AVS_WRITEDATA(wd),
    .I_AVS_BYTEENABLE(be),
    .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(wreq),
    .I_RAW_EVENT(ev),
    .O_MASKED_STATE(msk),
    .O_IRQ(irq)
  );

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    be <= bl;
    do @(posedge I_CLK); while (wreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // Outputs looked at mid-cycle, once the edge has settled
  task outs;
    @(negedge I_CLK);
    chk("masked", {27'h0, msk}, raw & en);
    chk("irq", {31'h0, irq}, 32'((raw & en) != 0));
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Generous ceiling: the whole run needs well under a thousand cycles
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      close_out;
    end
  end

  initial begin
    repeat (4) @(posedge I_CLK);
    I_RESETN <= 1'b1;
    bus(1'b0, 8'h00, 32'h0);
    chk("mask_reset", q, 32'h0);
    outs;
    $display("test reset done");
    // Writes come back only in bits 8:4, gated by byte lane after the first
    for (int i = 0; i < 8; i++) begin
      // Reserved low bits written back as read
      r = ((i == 0) ? 32'hffff_ffff : $random(seed)) & 32'hffff_fff0;
      bl = (i == 0) ? 4'hf : 4'($random(seed));
      lm = {bl[1], {4{bl[0]}}};
      bus(1'b1, 8'h00, r);
      en = (en & ~lm) | (r[8:4] & lm);
      bl = 4'hf;
      bus(1'b0, 8'h00, 32'h0);
      chk("mask_read", q, en << 4);
    end
    bus(1'b1, 8'h0c, 32'hffff_ffff);
    bus(1'b0, 8'h0c, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("test readback done");
    // Masking with events, sticky raw state and clearing
    for (int i = 0; i < 12; i++) begin
      r = (i == 0) ? 32'h0 : $random(seed);
      s = $random(seed);
      bus(1'b1, 8'h00, r);
      en = r[8:4];
      outs;
      @(posedge I_CLK);
      ev <= (i == 0) ? 5'h1f : s[4:0];
      @(posedge I_CLK);
      raw = raw | ev;
      ev <= 5'h00;
      outs;
      bus(1'b0, 8'h04, 32'h0);
      chk("raw_read", q, raw << 4);
      bus(1'b0, 8'h08, 32'h0);
      chk("masked_read", q, (raw & en) << 4);
      s = $random(seed);
      bl = s[31:28];
      lm = {bl[1], {4{bl[0]}}};
      bus(1'b1, 8'h04, s);
      raw = raw & ~(s[8:4] & lm);
      bl = 4'hf;
      outs;
    end
    $display("test events done");
    // Reset again in mid-run with every source set and enabled
    bus(1'b1, 8'h00, 32'hffff_fff0);
    en = 32'h1f;
    @(posedge I_CLK);
    ev <= 5'h1f;
    @(posedge I_CLK);
    raw = raw | ev;
    I_RESETN <= 1'b0;
    outs;
    repeat (2) @(posedge I_CLK);
    I_RESETN <= 1'b1;
    ev <= 5'h00;
    en = 0;
    raw = 0;
    outs;
    bus(1'b0, 8'h00, 32'h0);
    chk("mask_reset2", q, 32'h0);
    bus(1'b0, 8'h04, 32'h0);
    chk("raw_reset2", q, 32'h0);
    $display("test mid-run reset done");
    close_out;
  end
endmodule // tb
